// File: hdl/spe_regs.svh
/*
 * register offsets, field positions and reset values of the serial port
 * block. assumes a 32-bit avalon-mm slave with byte addresses.
 */
`ifndef SPE_REGS_SVH
`define SPE_REGS_SVH

// -------------------------------------------------
// offsets
// -------------------------------------------------
`define SPE_OFF_CTRL 4'h0
`define SPE_OFF_TX 4'h4
`define SPE_OFF_RX 4'h8
`define SPE_OFF_STAT 4'hC

// -------------------------------------------------
// fields
// -------------------------------------------------
`define SPE_CTRL_SEC_BIT 0
`define SPE_CTRL_TEN_BIT 10
`define SPE_CTRL_ELEVEN_BIT 11
`define SPE_STAT_BUSY_BIT 0
`define SPE_STAT_RXV_BIT 1
`define SPE_STAT_WB_BIT 2
`define SPE_STAT_WSEL_BIT 3

// -------------------------------------------------
// reset values and sizes
// -------------------------------------------------
`define SPE_CTRL_RESET 32'h0000_0000
`define SPE_DATA_RESET 16'h0000
`define SPE_WORD_BITS 16

`endif

// File: hdl/spe_pkg.sv
/*
 * types shared by the serial port block.
 * assumes spe_regs.svh for all numeric constants.
 */
package spe_pkg;

	// -------------------------------------------------
	// types
	// -------------------------------------------------
	typedef logic [3:0] spe_addr_t;
	typedef logic [31:0] spe_bus_word_t;
	typedef enum logic [1:0] {
		SPE_L_IDLE,
		SPE_L_SHIFT,
		SPE_L_GAP
	} spe_link_state_t;

endpackage

// File: hdl/spe_serial_port.sv
/*
 * serial port of the analog interface device: shifts converter words out,
 * host words in, drives end-of-data strobes, frame syncs and control pins.
 * assumes clk and shift_clk unrelated; host_serial_in is timed by shift_clk;
 * mode pins are asynchronous straps.
 */
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "spe_regs.svh"

// Functional notes
// R1 - mode_select high selects word or byte mode, strobes and format pin
// R2 - host picks word or byte format with word_byte_sel level
// R3 - converter bits leave msb first on converter_serial_out per shift_clk
// R4 - host bits on host_serial_in are sampled on shift_clk rising edges
// R5 - in dual-word mode ctrl_bit_ten drives ctrl_bit_ten_pin
// R6 - reset clears ctrl_bit_ten, pin low
// R7 - ctrl_bit_ten_pin follows a write at once, no frame wait
// R8 - in dual-word mode ctrl_bit_eleven drives ctrl_bit_eleven_pin
// R9 - reset clears ctrl_bit_eleven, pin low
// R10 - ctrl_bit_eleven_pin follows a write at once
// R11 - word mode: one low pulse on tx end strobe after 16 host bits
// R12 - byte mode: tx end strobe low from first host byte to second
// R13 - word mode: one low pulse on rx end strobe after 16 output bits
// R14 - byte mode: rx end strobe low from first output byte to second
// R15 - secondary frame sync high in primary, follows frame sync in secondary
// R16 - strobes rest high; byte mode sends a word as two bytes
module spe_serial_port
#(
	parameter int WORD_BITS = `SPE_WORD_BITS
)
(
	// system
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave
	input wire spe_pkg::spe_addr_t avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire spe_pkg::spe_bus_word_t avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output spe_pkg::spe_bus_word_t avs_readdata,
	output logic avs_waitrequest,
	// mode straps
	input wire logic mode_select,
	input wire logic word_byte_sel,
	// serial link
	input wire logic shift_clk,
	input wire logic host_serial_in,
	output logic converter_serial_out,
	output logic transmit_frame_sync_n,
	output logic secondary_frame_sync_n,
	output logic tx_end_strobe_n,
	output logic rx_end_strobe_n,
	// control pins
	output logic ctrl_bit_ten_pin,
	output logic ctrl_bit_eleven_pin
);
	import spe_pkg::*;

	localparam int HALF = WORD_BITS / 2;
	localparam int CW = $clog2(WORD_BITS);

	// -------------------------------------------------
	// elaboration checks
	// -------------------------------------------------
	if (WORD_BITS < 4 || WORD_BITS > 32 || (WORD_BITS % 2) != 0)
	begin : g_bad_width
		$error("WORD_BITS must be even and within 4 to 32");
	end

	// -------------------------------------------------
	// system domain state
	// -------------------------------------------------
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [WORD_BITS-1:0] tx_data_reg;
	logic [WORD_BITS-1:0] rx_data_reg;
	logic tx_sec_reg;
	logic rx_valid_reg;
	logic req_tgl_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	logic ack_s3_reg;
	logic mode_s1_reg;
	logic mode_s2_reg;
	logic wsel_s1_reg;
	logic wsel_s2_reg;
	logic rd_done_reg;
	logic [31:0] readdata_reg;
	logic ten_pin_reg;
	logic eleven_pin_reg;
	logic busy;
	logic done_pulse;
	logic wr_ok;
	logic rd_take;

	// -------------------------------------------------
	// link domain state
	// -------------------------------------------------
	spe_link_state_t lstate_reg;
	logic lrst_s1_reg;
	logic lrst_s2_reg;
	logic req_l1_reg;
	logic req_l2_reg;
	logic req_l3_reg;
	logic lmode_s1_reg;
	logic lmode_s2_reg;
	logic lwsel_s1_reg;
	logic lwsel_s2_reg;
	logic ack_tgl_reg;
	logic [CW-1:0] bit_cnt_reg;
	logic [WORD_BITS-1:0] tx_sh_reg;
	logic [WORD_BITS-1:0] rx_sh_reg;
	logic [WORD_BITS-1:0] rx_hold_reg;
	logic frame_wb_reg;
	logic frame_byte_reg;
	logic frame_sec_reg;
	logic dout_reg;
	logic fs_n_reg;
	logic sec_fs_n_reg;
	logic tx_eod_n_reg;
	logic rx_eod_n_reg;
	logic start_evt;
	logic last_bit;
	logic first_half_end;

	// -------------------------------------------------
	// byte-lane merge
	// -------------------------------------------------
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// -------------------------------------------------
	// bus handshake
	// -------------------------------------------------
	assign busy = req_tgl_reg ^ ack_s2_reg;
	assign done_pulse = ack_s2_reg ^ ack_s3_reg;
	assign rd_take = avs_read && rd_done_reg;

	always_comb
	begin
		avs_waitrequest = 1'b0;
		if (avs_read)
		begin
			avs_waitrequest = !rd_done_reg;
		end
		else if (avs_write && avs_address == `SPE_OFF_TX)
		begin
			avs_waitrequest = busy;
		end
	end

	assign wr_ok = avs_write && !avs_waitrequest;
	assign avs_readdata = readdata_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rd_done_reg <= 1'b0;
		end
		else
		begin
			rd_done_reg <= avs_read && !rd_done_reg;
		end
	end

	// -------------------------------------------------
	// read data
	// -------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			readdata_reg <= 32'h0000_0000;
		end
		else if (avs_read && !rd_done_reg)
		begin
			readdata_reg <= 32'h0000_0000;
			if (avs_address == `SPE_OFF_CTRL)
			begin
				readdata_reg <= ctrl_reg;
			end
			else if (avs_address == `SPE_OFF_TX)
			begin
				readdata_reg[WORD_BITS-1:0] <= tx_data_reg;
			end
			else if (avs_address == `SPE_OFF_RX)
			begin
				readdata_reg[WORD_BITS-1:0] <= rx_data_reg;
			end
			else if (avs_address == `SPE_OFF_STAT)
			begin
				readdata_reg[`SPE_STAT_BUSY_BIT] <= busy;
				readdata_reg[`SPE_STAT_RXV_BIT] <= rx_valid_reg;
				readdata_reg[`SPE_STAT_WB_BIT] <= mode_s2_reg;
				readdata_reg[`SPE_STAT_WSEL_BIT] <= wsel_s2_reg;
			end
		end
	end

	// -------------------------------------------------
	// control register and pins
	// -------------------------------------------------
	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (wr_ok && avs_address == `SPE_OFF_CTRL)
		begin
			ctrl_next = lane_merge(ctrl_reg, avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl_reg <= `SPE_CTRL_RESET; // R6 R9
		end
		else
		begin
			ctrl_reg <= ctrl_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ten_pin_reg <= 1'b0; // R6
			eleven_pin_reg <= 1'b0; // R9
		end
		else
		begin
			// same edge as the write
			ten_pin_reg <= !mode_s2_reg && ctrl_next[`SPE_CTRL_TEN_BIT]; // R5 R7
			eleven_pin_reg <= !mode_s2_reg &&
				ctrl_next[`SPE_CTRL_ELEVEN_BIT]; // R8 R10
		end
	end

	assign ctrl_bit_ten_pin = ten_pin_reg;
	assign ctrl_bit_eleven_pin = eleven_pin_reg;

	// -------------------------------------------------
	// outbound word and frame request
	// -------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tx_data_reg <= `SPE_DATA_RESET;
			tx_sec_reg <= 1'b0;
			req_tgl_reg <= 1'b0;
		end
		else if (wr_ok && avs_address == `SPE_OFF_TX)
		begin
			tx_data_reg <= WORD_BITS'(lane_merge(32'(tx_data_reg),
				avs_writedata, avs_byteenable));
			tx_sec_reg <= ctrl_reg[`SPE_CTRL_SEC_BIT];
			req_tgl_reg <= !req_tgl_reg;
		end
	end

	// -------------------------------------------------
	// inbound word
	// -------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_data_reg <= `SPE_DATA_RESET;
		end
		else if (done_pulse)
		begin
			rx_data_reg <= rx_hold_reg;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_valid_reg <= 1'b0;
		end
		else if (done_pulse)
		begin
			rx_valid_reg <= 1'b1;
		end
		else if (rd_take && avs_address == `SPE_OFF_RX)
		begin
			rx_valid_reg <= 1'b0;
		end
	end

	// -------------------------------------------------
	// system domain synchronisers
	// -------------------------------------------------
	always_ff @(posedge clk)
	begin
		ack_s1_reg <= ack_tgl_reg;
		ack_s2_reg <= ack_s1_reg;
		ack_s3_reg <= ack_s2_reg;
		mode_s1_reg <= mode_select;
		mode_s2_reg <= mode_s1_reg;
		wsel_s1_reg <= word_byte_sel;
		wsel_s2_reg <= wsel_s1_reg;
	end

	// -------------------------------------------------
	// link domain synchronisers
	// -------------------------------------------------
	always_ff @(posedge shift_clk)
	begin
		lrst_s1_reg <= rst;
		lrst_s2_reg <= lrst_s1_reg;
		req_l1_reg <= req_tgl_reg;
		req_l2_reg <= req_l1_reg;
		req_l3_reg <= req_l2_reg;
		lmode_s1_reg <= mode_select;
		lmode_s2_reg <= lmode_s1_reg;
		lwsel_s1_reg <= word_byte_sel;
		lwsel_s2_reg <= lwsel_s1_reg;
	end

	assign start_evt = req_l2_reg ^ req_l3_reg;
	assign last_bit = bit_cnt_reg == CW'(WORD_BITS - 1);
	assign first_half_end = frame_byte_reg && bit_cnt_reg == CW'(HALF - 1);

	// -------------------------------------------------
	// link frame engine
	// -------------------------------------------------
	always_ff @(posedge shift_clk)
	begin
		if (lrst_s2_reg)
		begin
			lstate_reg <= SPE_L_IDLE;
			bit_cnt_reg <= '0;
			frame_wb_reg <= 1'b0;
			frame_byte_reg <= 1'b0;
			frame_sec_reg <= 1'b0;
			fs_n_reg <= 1'b1;
			sec_fs_n_reg <= 1'b1;
			ack_tgl_reg <= 1'b0;
		end
		else
		begin
			case (lstate_reg)
				SPE_L_IDLE:
				begin
					fs_n_reg <= 1'b1;
					sec_fs_n_reg <= 1'b1;
					if (start_evt)
					begin
						frame_wb_reg <= lmode_s2_reg; // R1
						frame_byte_reg <= lmode_s2_reg && !lwsel_s2_reg; // R2
						frame_sec_reg <= tx_sec_reg;
						bit_cnt_reg <= '0;
						fs_n_reg <= 1'b0;
						sec_fs_n_reg <= lmode_s2_reg || !tx_sec_reg; // R15
						lstate_reg <= SPE_L_SHIFT;
					end
				end
				SPE_L_SHIFT:
				begin
					bit_cnt_reg <= bit_cnt_reg + 1'b1;
					if (last_bit)
					begin
						fs_n_reg <= 1'b1;
						sec_fs_n_reg <= 1'b1;
						ack_tgl_reg <= !ack_tgl_reg;
						lstate_reg <= SPE_L_IDLE;
					end
					else if (first_half_end)
					begin
						fs_n_reg <= 1'b1; // R16
						sec_fs_n_reg <= 1'b1;
						lstate_reg <= SPE_L_GAP;
					end
				end
				SPE_L_GAP:
				begin
					fs_n_reg <= 1'b0;
					sec_fs_n_reg <= frame_wb_reg || !frame_sec_reg; // R15
					lstate_reg <= SPE_L_SHIFT;
				end
				default:
				begin
					lstate_reg <= SPE_L_IDLE;
				end
			endcase
		end
	end

	// -------------------------------------------------
	// link data path
	// -------------------------------------------------
	always_ff @(posedge shift_clk)
	begin
		if (lrst_s2_reg)
		begin
			tx_sh_reg <= '0;
			dout_reg <= 1'b0;
		end
		else if (lstate_reg == SPE_L_IDLE && start_evt)
		begin
			dout_reg <= tx_data_reg[WORD_BITS-1]; // R3
			tx_sh_reg <= {tx_data_reg[WORD_BITS-2:0], 1'b0};
		end
		else if (lstate_reg == SPE_L_GAP ||
			(lstate_reg == SPE_L_SHIFT && !last_bit && !first_half_end))
		begin
			dout_reg <= tx_sh_reg[WORD_BITS-1]; // R3
			tx_sh_reg <= {tx_sh_reg[WORD_BITS-2:0], 1'b0};
		end
		else if (lstate_reg == SPE_L_SHIFT)
		begin
			dout_reg <= 1'b0;
		end
	end

	always_ff @(posedge shift_clk)
	begin
		if (lrst_s2_reg)
		begin
			rx_sh_reg <= '0;
			rx_hold_reg <= '0;
		end
		else if (lstate_reg == SPE_L_SHIFT)
		begin
			rx_sh_reg <= {rx_sh_reg[WORD_BITS-2:0], host_serial_in}; // R4
			if (last_bit)
			begin
				rx_hold_reg <= {rx_sh_reg[WORD_BITS-2:0], host_serial_in};
			end
		end
	end

	// -------------------------------------------------
	// end-of-data strobes
	// -------------------------------------------------
	always_ff @(posedge shift_clk)
	begin
		if (lrst_s2_reg)
		begin
			tx_eod_n_reg <= 1'b1;
			rx_eod_n_reg <= 1'b1;
		end
		else if (lstate_reg == SPE_L_SHIFT && frame_wb_reg)
		begin
			if (first_half_end)
			begin
				tx_eod_n_reg <= 1'b0; // R12
				rx_eod_n_reg <= 1'b0; // R14
			end
			else if (last_bit)
			begin
				// word mode pulses, byte mode releases
				tx_eod_n_reg <= frame_byte_reg; // R11 R12
				rx_eod_n_reg <= frame_byte_reg; // R13 R14
			end
		end
		else if (lstate_reg == SPE_L_IDLE)
		begin
			tx_eod_n_reg <= 1'b1; // R16
			rx_eod_n_reg <= 1'b1; // R16
		end
	end

	assign converter_serial_out = dout_reg;
	assign transmit_frame_sync_n = fs_n_reg;
	assign secondary_frame_sync_n = sec_fs_n_reg;
	assign tx_end_strobe_n = tx_eod_n_reg;
	assign rx_end_strobe_n = rx_eod_n_reg;

endmodule
`default_nettype wire

// File: test/spe_assertions.sv
/*
 * checker of the serial port block, bound to its top module.
 * assumes straps change only while the link is idle.
 */
`timescale 1ns/1ns
`default_nettype none
module spe_assertions
#(
	parameter int WORD_BITS = 16
)
(
	// system
	input wire logic clk,
	input wire logic rst,
	// bus
	input wire spe_pkg::spe_addr_t avs_address,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire spe_pkg::spe_bus_word_t avs_writedata,
	input wire logic [3:0] avs_byteenable,
	// straps and link
	input wire logic mode_select,
	input wire logic word_byte_sel,
	input wire logic shift_clk,
	input wire logic transmit_frame_sync_n,
	input wire logic secondary_frame_sync_n,
	input wire logic tx_end_strobe_n,
	input wire logic rx_end_strobe_n,
	// control pins
	input wire logic ctrl_bit_ten_pin,
	input wire logic ctrl_bit_eleven_pin
);
	import spe_pkg::*;
	// ----
	// helpers
	// ----
	logic [2:0] hist;
	logic dual;
	logic wbm;
	logic ctrl_wr;
	logic sec_flag;
	always_ff @(posedge clk)
	begin
		hist <= {hist[1:0], mode_select};
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			sec_flag <= 1'b0;
		else if (avs_write && !avs_waitrequest && avs_address == 4'h0
			&& avs_byteenable[0])
			sec_flag <= avs_writedata[0];
	end
	assign dual = hist == 3'b000 && !mode_select;
	assign wbm = hist == 3'b111 && mode_select;
	assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == 4'h0
		&& avs_byteenable[1];
	// ----
	// properties
	// ----
	a_ten_pin_follow: assert property (@(posedge clk) disable iff (rst)
		ctrl_wr && dual |=> ctrl_bit_ten_pin == $past(avs_writedata[10]))
		else $error("ten pin wrong");
	a_eleven_pin_follow: assert property (
		@(posedge clk) disable iff (rst)
		ctrl_wr && dual |=> ctrl_bit_eleven_pin == $past(avs_writedata[11]))
		else $error("eleven pin wrong");
	a_pins_cleared: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> !ctrl_bit_ten_pin && !ctrl_bit_eleven_pin)
		else $error("pins not cleared");
	a_dual_no_strobe: assert property (@(posedge clk) disable iff (rst)
		dual |-> tx_end_strobe_n && rx_end_strobe_n)
		else $error("strobe in dual mode");
	a_strobes_match: assert property (
		@(posedge shift_clk) disable iff (rst)
		tx_end_strobe_n == rx_end_strobe_n)
		else $error("strobes differ");
	a_word_pulse: assert property (
		@(posedge shift_clk) disable iff (rst)
		$fell(tx_end_strobe_n) && wbm && word_byte_sel |=> tx_end_strobe_n)
		else $error("word pulse length");
	a_byte_mark: assert property (
		@(posedge shift_clk) disable iff (rst)
		$fell(tx_end_strobe_n) && wbm && !word_byte_sel
		|-> ##1 (!tx_end_strobe_n)[*8] ##1 tx_end_strobe_n)
		else $error("byte mark length");
	a_sec_fs_primary: assert property (
		@(posedge shift_clk) disable iff (rst)
		wbm |-> secondary_frame_sync_n)
		else $error("secondary sync low");
	a_sec_fs_dual: assert property (
		@(posedge shift_clk) disable iff (rst)
		$fell(transmit_frame_sync_n) && dual && sec_flag
		|-> !secondary_frame_sync_n)
		else $error("secondary sync missing");
	a_sec_fs_follow: assert property (
		@(posedge shift_clk) disable iff (rst)
		!secondary_frame_sync_n |-> !transmit_frame_sync_n)
		else $error("secondary sync alone");
	a_byte_halves: assert property (@(posedge shift_clk) disable iff (rst)
		$fell(transmit_frame_sync_n) && wbm && !word_byte_sel
		|-> ##1 (!transmit_frame_sync_n)[*7] ##1 transmit_frame_sync_n)
		else $error("byte length");
	a_word_frame: assert property (@(posedge shift_clk) disable iff (rst)
		$fell(transmit_frame_sync_n) && wbm && word_byte_sel
		|-> ##1 (!transmit_frame_sync_n)[*8] ##1 (!transmit_frame_sync_n)[*7]
		##1 transmit_frame_sync_n)
		else $error("word length");
	c_word: cover property (@(posedge shift_clk) $fell(tx_end_strobe_n)
		&& word_byte_sel);
	c_byte: cover property (@(posedge shift_clk) $fell(tx_end_strobe_n)
		&& !word_byte_sel);
	c_pin: cover property (@(posedge clk) $rose(ctrl_bit_ten_pin));
	c_sec: cover property (@(posedge shift_clk) $fell(secondary_frame_sync_n));
endmodule
`default_nettype wire

// File: test/spe_host_model.sv
/*
 * host serial port model: sends a word, collects the device word.
 * assumes the device samples on shift_clk rise; the model moves on the fall.
 */
`timescale 1ns/1ns
`default_nettype none
module spe_host_model
(
	// link
	input wire logic shift_clk,
	input wire logic frame_sync_n,
	input wire logic dev_out,
	input wire logic strobe_n,
	output logic host_out,
	// bench side
	input wire logic [15:0] send_word,
	output logic [15:0] got_word,
	output int low_cnt
);
	int idx = 15;
	initial host_out = 1'b0;
	initial got_word = 16'h0000;
	initial low_cnt = 0;
	always @(negedge shift_clk)
	begin
		if (!frame_sync_n)
		begin
			host_out <= send_word[idx];
			got_word <= {got_word[14:0], dev_out};
			idx <= idx - 1;
		end
		else
		begin
			host_out <= ~host_out;
			if (idx < 0)
				idx <= 15;
		end
	end
	always @(posedge shift_clk)
	begin
		if (!strobe_n)
			low_cnt <= low_cnt + 1;
	end
endmodule
`default_nettype wire

// File: test/tb_serial_port_eod_and_ctrl_outputs.sv
/*
 * self-checking bench of the serial port block.
 * assumes spe_pkg and spe_regs.svh compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_serial_port_eod_and_ctrl_outputs;
	import spe_pkg::*;
	// ----
	// signals
	// ----
	logic clk = 1'b0;
	logic shift_clk = 1'b0;
	logic rst = 1'b1;
	spe_addr_t avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	spe_bus_word_t avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	spe_bus_word_t avs_readdata;
	logic avs_waitrequest;
	logic mode_select = 1'b0;
	logic word_byte_sel = 1'b1;
	logic host_serial_in;
	logic converter_serial_out;
	logic transmit_frame_sync_n;
	logic secondary_frame_sync_n;
	logic tx_end_strobe_n;
	logic rx_end_strobe_n;
	logic ctrl_bit_ten_pin;
	logic ctrl_bit_eleven_pin;
	logic [15:0] hword = 16'h0000;
	logic [15:0] got;
	int low_cnt;
	int n_errors = 0;
	int comparisons = 0;
	logic [31:0] seed = 32'h0000_9ff8;
	spe_bus_word_t q;
	spe_bus_word_t d;
	always #25 clk = ~clk;
	initial #7 forever #24 shift_clk = ~shift_clk;
	spe_serial_port i_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.mode_select(mode_select), .word_byte_sel(word_byte_sel),
		.shift_clk(shift_clk), .host_serial_in(host_serial_in),
		.converter_serial_out(converter_serial_out),
		.transmit_frame_sync_n(transmit_frame_sync_n),
		.secondary_frame_sync_n(secondary_frame_sync_n),
		.tx_end_strobe_n(tx_end_strobe_n), .rx_end_strobe_n(rx_end_strobe_n),
		.ctrl_bit_ten_pin(ctrl_bit_ten_pin),
		.ctrl_bit_eleven_pin(ctrl_bit_eleven_pin));
	spe_host_model i_host (.shift_clk(shift_clk),
		.frame_sync_n(transmit_frame_sync_n), .dev_out(converter_serial_out),
		.strobe_n(tx_end_strobe_n), .host_out(host_serial_in),
		.send_word(hword), .got_word(got), .low_cnt(low_cnt));
	// ----
	// tasks
	// ----
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
		comparisons++;
		if (got_v !== exp_v)
		begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got_v, exp_v);
		end
	endtask
	task automatic bus(input logic wr, input spe_addr_t a,
		input spe_bus_word_t wd, output spe_bus_word_t rd);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic frame(input logic [15:0] tw, input int exp_low);
		spe_bus_word_t r;
		int base;
		base = low_cnt;
		hword = 16'(rnd());
		bus(1'b1, 4'h4, {16'h0000, tw}, r);
		r = 32'h0000_0000;
		repeat (200)
			if (r[1:0] !== 2'b10)
				bus(1'b0, 4'hc, 32'h0000_0000, r);
		bus(1'b0, 4'h8, 32'h0000_0000, r);
		chk(32'(r[15:0]), 32'(hword));
		chk(32'(got), 32'(tw));
		chk(low_cnt - base, exp_low);
	endtask
	task automatic print_verdict();
		$display("n_errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ----
	// sequence
	// ----
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		print_verdict();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge shift_clk);
		@(negedge clk);
		chk(32'({ctrl_bit_ten_pin, ctrl_bit_eleven_pin}), 0);
		chk(32'({tx_end_strobe_n, rx_end_strobe_n}), 3);
		bus(1'b0, 4'h0, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		bus(1'b0, 4'h2, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		for (int i = 0; i < 6; i++)
		begin
			d = (i == 0) ? 32'h0000_0c00 : (i == 1) ? 32'h0000_0000 : rnd();
			bus(1'b1, 4'h0, d, q);
			@(negedge clk);
			chk(32'({ctrl_bit_ten_pin, ctrl_bit_eleven_pin}),
				32'({d[10], d[11]}));
		end
		for (int m = 0; m < 3; m++)
		begin
			@(posedge clk);
			mode_select <= (m < 2);
			word_byte_sel <= (m != 1);
			repeat (4) @(posedge clk);
			bus(1'b0, 4'hc, 32'h0000_0000, q);
			chk(32'(q[3:2]), 32'({word_byte_sel, mode_select}));
			chk(32'({ctrl_bit_ten_pin, ctrl_bit_eleven_pin}),
				m < 2 ? 0 : 32'({d[10], d[11]}));
			if (m == 2)
				bus(1'b1, 4'h0, d | 32'h0000_0001, q);
			for (int k = 0; k < 3; k++)
				frame(k == 0 ? 16'hffff : 16'(rnd()),
					m == 0 ? 1 : m == 1 ? 9 : 0);
		end
		print_verdict();
	end
endmodule
bind spe_serial_port spe_assertions #(.WORD_BITS(WORD_BITS)) i_chk (
	.clk(clk), .rst(rst), .avs_address(avs_address), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .mode_select(mode_select),
	.word_byte_sel(word_byte_sel), .shift_clk(shift_clk),
	.transmit_frame_sync_n(transmit_frame_sync_n),
	.secondary_frame_sync_n(secondary_frame_sync_n),
	.tx_end_strobe_n(tx_end_strobe_n), .rx_end_strobe_n(rx_end_strobe_n),
	.ctrl_bit_ten_pin(ctrl_bit_ten_pin),
	.ctrl_bit_eleven_pin(ctrl_bit_eleven_pin));
`default_nettype wire
